// File: src/ccta_pkg.sv
package ccta_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 24;
  localparam int WORD_W = ADDR_W - 2;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam logic [WORD_W-1:0] IDX_IRQ_MASK = 22'h040150;
  localparam logic [WORD_W-1:0] IDX_RUN_STOP = 22'h040151;
  localparam logic [WORD_W-1:0] IDX_EVENT_CTRL = 22'h040152;
  localparam logic [WORD_W-1:0] IDX_DIVIDER_TAPS = 22'h040153;
  localparam logic [WORD_W-1:0] IDX_SECONDS = 22'h040154;
  localparam logic [WORD_W-1:0] IDX_MINUTES = 22'h040155;
  localparam logic [WORD_W-1:0] IDX_HOURS = 22'h040156;
  localparam logic [WORD_W-1:0] IDX_DAYS_LOW = 22'h040157;
  localparam logic [WORD_W-1:0] IDX_DAYS_HIGH = 22'h040158;
  localparam logic [WORD_W-1:0] IDX_MINUTE_ALARM = 22'h040159;
  localparam logic [WORD_W-1:0] IDX_HOUR_ALARM = 22'h04015a;
  localparam logic [WORD_W-1:0] IDX_DAY_ALARM = 22'h04015b;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RUN_BIT = 0;
  localparam int CLEAR_BIT = 1;
  localparam int ALARM_FLAG_BIT = 0;
  localparam int PERIODIC_FLAG_BIT = 1;
  localparam int ALARM_EN_LSB = 2;
  localparam int EVENT_SEL_LSB = 5;
  localparam int ALARM_EN_MINUTE = 0;
  localparam int ALARM_EN_HOUR = 1;
  localparam int ALARM_EN_DAY = 2;

  // ----------------------------------------
  // counter limits and timing
  // ----------------------------------------
  localparam logic [5:0] SECONDS_MAX = 6'h3b;
  localparam logic [5:0] MINUTES_MAX = 6'h3b;
  localparam logic [4:0] HOURS_MAX = 5'h17;
  localparam logic [7:0] DIV_LAST = 8'hff;
  localparam logic [7:0] DIV_MASK_32HZ = 8'h07;
  localparam logic [7:0] DIV_MASK_8HZ = 8'h1f;
  localparam logic [7:0] DIV_MASK_2HZ = 8'h7f;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BASE_TICK_HZ = 256;
  localparam int PRESCALE_CYCLES = 1000000000 / (CLK_PERIOD_NS * BASE_TICK_HZ);
  localparam int PRE_W = 17;

  typedef enum logic [2:0] {
    CCTA_EV_32HZ = 3'h0,
    CCTA_EV_8HZ = 3'h1,
    CCTA_EV_2HZ = 3'h2,
    CCTA_EV_1HZ = 3'h3,
    CCTA_EV_MINUTE = 3'h4,
    CCTA_EV_HOUR = 3'h5,
    CCTA_EV_DAY = 3'h6,
    CCTA_EV_NONE = 3'h7
  } ccta_event_sel_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } ccta_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [DATA_W-1:0] dat;
  } ccta_wb_rsp_t;

  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [7:0] divider;
    logic [5:0] seconds;
    logic [5:0] minutes;
    logic [4:0] hours;
    logic [15:0] days;
    logic [5:0] minuteAlarm;
    logic [4:0] hourAlarm;
    logic [4:0] dayAlarm;
    logic run;
    ccta_event_sel_t eventSel;
    logic [2:0] alarmEnable;
    logic periodicEventFlag;
    logic alarmHitFlag;
    logic [1:0] irqMask;
    logic alarmCheck;
    logic irq;
    ccta_wb_rsp_t rsp;
  } ccta_state_t;

endpackage

// File: src/ccta_top.sv
`timescale 1ns/1ns
module ccta_top
  import ccta_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_CYCLES
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire ccta_wb_req_t wbReq, // wishbone request from master
  output ccta_wb_rsp_t wbRsp, // wishbone ack and read data
  output logic irq // level interrupt
);

  ccta_state_t s;
  ccta_state_t next_s;

  logic access;
  logic writeByte;
  logic [7:0] wd;
  logic [WORD_W-1:0] wordAddr;
  logic baseTick;
  logic secondTick;
  logic minuteCarry;
  logic hourCarry;
  logic dayCarry;
  logic periodicHit;
  logic alarmMatch;
  logic clearPeriodic;
  logic clearAlarm;
  logic [7:0] rd;

  always_comb begin
    next_s = s;
    next_s.rsp.ack = 1'b0;
    access = wbReq.cyc & wbReq.stb & ~s.rsp.ack;
    writeByte = access & wbReq.we & wbReq.sel[0];
    wd = wbReq.dat[7:0];
    wordAddr = wbReq.adr[ADDR_W-1:2];
    baseTick = 1'b0;
    secondTick = 1'b0;
    minuteCarry = 1'b0;
    hourCarry = 1'b0;
    dayCarry = 1'b0;
    periodicHit = 1'b0;
    alarmMatch = 1'b0;
    clearPeriodic = 1'b0;
    clearAlarm = 1'b0;
    rd = 8'h00;

    // ----------------------------------------
    // prescaler and divider chain
    // ----------------------------------------
    if (s.run) begin
      if (s.pre == PRE_W'(PRESCALE - 1)) begin
        next_s.pre = '0;
        baseTick = 1'b1;
      end else begin
        next_s.pre = s.pre + 1'b1;
      end
    end
    if (baseTick) begin
      next_s.divider = s.divider + 8'h01;
      secondTick = (s.divider == DIV_LAST);
    end

    // ----------------------------------------
    // time of day counters
    // ----------------------------------------
    if (secondTick) begin
      if (s.seconds >= SECONDS_MAX) begin
        next_s.seconds = 6'h00;
        minuteCarry = 1'b1;
      end else begin
        next_s.seconds = s.seconds + 6'h01;
      end
    end
    if (minuteCarry) begin
      if (s.minutes >= MINUTES_MAX) begin
        next_s.minutes = 6'h00;
        hourCarry = 1'b1;
      end else begin
        next_s.minutes = s.minutes + 6'h01;
      end
    end
    if (hourCarry) begin
      if (s.hours >= HOURS_MAX) begin
        next_s.hours = 5'h00;
        dayCarry = 1'b1;
      end else begin
        next_s.hours = s.hours + 5'h01;
      end
    end
    if (dayCarry) begin
      next_s.days = s.days + 16'h0001;
    end

    // ----------------------------------------
    // periodic event source
    // ----------------------------------------
    unique case (s.eventSel)
      CCTA_EV_32HZ: periodicHit = baseTick && ((s.divider & DIV_MASK_32HZ) == DIV_MASK_32HZ);
      CCTA_EV_8HZ: periodicHit = baseTick && ((s.divider & DIV_MASK_8HZ) == DIV_MASK_8HZ);
      CCTA_EV_2HZ: periodicHit = baseTick && ((s.divider & DIV_MASK_2HZ) == DIV_MASK_2HZ);
      CCTA_EV_1HZ: periodicHit = secondTick;
      CCTA_EV_MINUTE: periodicHit = minuteCarry;
      CCTA_EV_HOUR: periodicHit = hourCarry;
      CCTA_EV_DAY: periodicHit = dayCarry;
      CCTA_EV_NONE: periodicHit = 1'b0;
    endcase

    // ----------------------------------------
    // alarm comparison, one cycle after a minute step
    // ----------------------------------------
    next_s.alarmCheck = minuteCarry;
    if (s.alarmCheck && (s.alarmEnable != 3'h0)) begin
      alarmMatch =
        (!s.alarmEnable[ALARM_EN_MINUTE] || (s.minutes == s.minuteAlarm)) &&
        (!s.alarmEnable[ALARM_EN_HOUR] || (s.hours == s.hourAlarm)) &&
        (!s.alarmEnable[ALARM_EN_DAY] || (s.days[4:0] == s.dayAlarm));
    end

    // ----------------------------------------
    // register writes (software wins over counting)
    // ----------------------------------------
    if (writeByte) begin
      unique case (wordAddr)
        IDX_IRQ_MASK: next_s.irqMask = wd[1:0];
        IDX_RUN_STOP: begin
          next_s.run = wd[RUN_BIT];
          if (wd[CLEAR_BIT]) begin
            next_s.pre = '0;
            next_s.divider = 8'h00;
            next_s.seconds = 6'h00;
            next_s.minutes = 6'h00;
            next_s.hours = 5'h00;
            next_s.days = 16'h0000;
            next_s.alarmCheck = 1'b0;
          end
        end
        IDX_EVENT_CTRL: begin
          next_s.eventSel = ccta_event_sel_t'(wd[EVENT_SEL_LSB +: 3]);
          next_s.alarmEnable = wd[ALARM_EN_LSB +: 3];
          clearPeriodic = wd[PERIODIC_FLAG_BIT];
          clearAlarm = wd[ALARM_FLAG_BIT];
        end
        IDX_MINUTES: next_s.minutes = wd[5:0];
        IDX_HOURS: next_s.hours = wd[4:0];
        IDX_DAYS_LOW: next_s.days[7:0] = wd;
        IDX_DAYS_HIGH: next_s.days[15:8] = wd;
        IDX_MINUTE_ALARM: next_s.minuteAlarm = wd[5:0];
        IDX_HOUR_ALARM: next_s.hourAlarm = wd[4:0];
        IDX_DAY_ALARM: next_s.dayAlarm = wd[4:0];
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // sticky flags: a new event beats a clear
    // ----------------------------------------
    next_s.periodicEventFlag = (s.periodicEventFlag & ~clearPeriodic) | periodicHit;
    next_s.alarmHitFlag = (s.alarmHitFlag & ~clearAlarm) | alarmMatch;
    next_s.irq = |({next_s.periodicEventFlag, next_s.alarmHitFlag} & next_s.irqMask);

    // ----------------------------------------
    // read mux, unused bits read zero
    // ----------------------------------------
    unique case (wordAddr)
      IDX_IRQ_MASK: rd = {6'h00, s.irqMask};
      IDX_RUN_STOP: rd = {7'h00, s.run};
      IDX_EVENT_CTRL: rd = {s.eventSel, s.alarmEnable, s.periodicEventFlag, s.alarmHitFlag};
      IDX_DIVIDER_TAPS: rd = s.divider;
      IDX_SECONDS: rd = {2'h0, s.seconds};
      IDX_MINUTES: rd = {2'h0, s.minutes};
      IDX_HOURS: rd = {3'h0, s.hours};
      IDX_DAYS_LOW: rd = s.days[7:0];
      IDX_DAYS_HIGH: rd = s.days[15:8];
      IDX_MINUTE_ALARM: rd = {2'h0, s.minuteAlarm};
      IDX_HOUR_ALARM: rd = {3'h0, s.hourAlarm};
      IDX_DAY_ALARM: rd = {3'h0, s.dayAlarm};
      default: rd = 8'h00;
    endcase

    if (access) begin
      next_s.rsp.ack = 1'b1;
      next_s.rsp.dat = wbReq.we ? s.rsp.dat : {24'h000000, rd};
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wbRsp = s.rsp;
  assign irq = s.irq;

endmodule

// File: testbench/ccta_properties.sv
`timescale 1ns/1ns
module ccta_properties
  import ccta_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire ccta_wb_req_t wbReq, // bus request
  input wire ccta_wb_rsp_t wbRsp, // bus answer
  input wire logic irq // interrupt level
);
  logic rd;
  logic [WORD_W-1:0] ix;
  assign rd = wbRsp.ack && wbReq.cyc && !wbReq.we;
  assign ix = wbReq.adr[ADDR_W-1:2];
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  ack_one_cycle_a: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (!(wbReq.cyc && wbReq.stb) |=> !wbRsp.ack)
    else $error("ack without request");
  upper_zero_a: assert property (rd |-> wbRsp.dat[31:8] == 24'h0)
    else $error("read data above byte not zero");
  seconds_range_a: assert property (rd && ix == IDX_SECONDS |-> wbRsp.dat[7:0] <= 8'h3b)
    else $error("seconds out of range");
  hours_upper_a: assert property (rd && ix == IDX_HOURS |-> wbRsp.dat[7:5] == 3'h0)
    else $error("hours upper bits set");
  min_alarm_upper_a: assert property (rd && ix == IDX_MINUTE_ALARM |-> wbRsp.dat[7:6] == 2'h0)
    else $error("minute alarm upper bits set");
  hour_alarm_upper_a: assert property (rd && ix == IDX_HOUR_ALARM |-> wbRsp.dat[7:5] == 3'h0)
    else $error("hour alarm upper bits set");
  day_alarm_upper_a: assert property (rd && ix == IDX_DAY_ALARM |-> wbRsp.dat[7:5] == 3'h0)
    else $error("day alarm upper bits set");
  clear_reads_zero_a: assert property (rd && ix == IDX_RUN_STOP |-> wbRsp.dat[7:1] == 7'h0)
    else $error("clear bit not reading zero");
  cover property (wbRsp.ack && wbReq.we);
  cover property (rd && ix == IDX_EVENT_CTRL);
  cover property ($rose(irq));
endmodule
bind ccta_top ccta_properties u_props (.clock(clock), .sys_rst(sys_rst), .wbReq(wbReq),
  .wbRsp(wbRsp), .irq(irq));

// File: testbench/ccta_top_tb_top.sv
`timescale 1ns/1ns
module ccta_top_tb_top;
  import ccta_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  ccta_wb_req_t wbReq = '0;
  ccta_wb_rsp_t wbRsp;
  logic irq;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] q;
  ccta_top #(.PRESCALE(2)) uut (.clock(clock), .sys_rst(sys_rst), .wbReq(wbReq),
    .wbRsp(wbRsp), .irq(irq));
  always #20 clock = ~clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t byte mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [WORD_W-1:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: {idx, 2'b00}, dat: {24'h0, d}};
    do begin
      @(posedge clock);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    q = wbRsp.dat[7:0];
    if (n >= 20) chk(8'h00, 8'h01);
    wbReq <= '0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [WORD_W-1:0] ix[10] = '{IDX_MINUTES, IDX_HOURS, IDX_DAYS_LOW, IDX_DAYS_HIGH,
      IDX_MINUTE_ALARM, IDX_HOUR_ALARM, IDX_DAY_ALARM, IDX_SECONDS, 22'h040160, IDX_RUN_STOP};
    logic [7:0] ex[10] = '{8'h3f, 8'h1f, 8'ha5, 8'h5a, 8'h3f, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++) begin
      wb(1'b1, ix[i], (i == 2) ? 8'ha5 : (i == 3) ? 8'h5a : (i == 9) ? 8'hfe : 8'hff);
      wb(1'b0, ix[i], 8'h00);
      chk(q, ex[i]);
    end
  endtask
  task automatic t_count();
    wb(1'b1, IDX_RUN_STOP, 8'h02);
    wb(1'b1, IDX_MINUTES, 8'h3b);
    wb(1'b1, IDX_HOURS, 8'h17);
    wb(1'b1, IDX_DAYS_LOW, 8'h02);
    wb(1'b1, IDX_DAYS_HIGH, 8'h01);
    wb(1'b1, IDX_MINUTE_ALARM, 8'h00);
    wb(1'b1, IDX_HOUR_ALARM, 8'h00);
    wb(1'b1, IDX_DAY_ALARM, 8'h03);
    wb(1'b1, IDX_EVENT_CTRL, 8'hdc);
    wb(1'b1, IDX_IRQ_MASK, 8'h03);
    wb(1'b1, IDX_RUN_STOP, 8'h01);
    repeat (60 * 512 + 64) @(posedge clock);
    wb(1'b1, IDX_RUN_STOP, 8'h00);
    wb(1'b0, IDX_DIVIDER_TAPS, 8'h00);
    chk(q, 8'h21);
    wb(1'b0, IDX_SECONDS, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, IDX_MINUTES, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, IDX_HOURS, 8'h00);
    chk(q, 8'h00);
    wb(1'b0, IDX_DAYS_LOW, 8'h00);
    chk(q, 8'h03);
    wb(1'b0, IDX_DAYS_HIGH, 8'h00);
    chk(q, 8'h01);
    wb(1'b0, IDX_EVENT_CTRL, 8'h00);
    chk(q, 8'hdf);
    chk({7'h0, irq}, 8'h01);
    wb(1'b1, IDX_EVENT_CTRL, 8'hdf);
    wb(1'b0, IDX_EVENT_CTRL, 8'h00);
    chk(q, 8'hdc);
    chk({7'h0, irq}, 8'h00);
  endtask
  task automatic t_periodic();
    int per[8] = '{16, 64, 256, 512, 0, 0, 0, 520};
    for (int c = 0; c < 8; c++) begin
      if (per[c] != 0) begin
        wb(1'b1, IDX_RUN_STOP, 8'h02);
        wb(1'b1, IDX_EVENT_CTRL, {c[2:0], 5'h03});
        wb(1'b1, IDX_RUN_STOP, 8'h01);
        repeat (per[c] + 8) @(posedge clock);
        wb(1'b1, IDX_RUN_STOP, 8'h00);
        wb(1'b0, IDX_DIVIDER_TAPS, 8'h00);
        chk(q, 8'((per[c] + 11) / 2));
        wb(1'b1, IDX_EVENT_CTRL, {c[2:0], 5'h00});
        wb(1'b0, IDX_EVENT_CTRL, 8'h00);
        chk(q, {c[2:0], 3'h0, (c != 7), 1'b0});
        chk({7'h0, irq}, {7'h0, (c != 7)});
      end
    end
  endtask
  task automatic t_hour();
    wb(1'b1, IDX_RUN_STOP, 8'h02);
    wb(1'b1, IDX_MINUTES, 8'h3b);
    wb(1'b1, IDX_EVENT_CTRL, 8'ha3);
    wb(1'b1, IDX_RUN_STOP, 8'h01);
    repeat (60 * 512 + 64) @(posedge clock);
    wb(1'b1, IDX_RUN_STOP, 8'h00);
    wb(1'b0, IDX_EVENT_CTRL, 8'h00);
    chk(q, 8'ha2);
    wb(1'b0, IDX_HOURS, 8'h00);
    chk(q, 8'h01);
  endtask
  task automatic t_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    wb(1'b0, IDX_EVENT_CTRL, 8'h00);
    chk(q, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wb(1'b0, IDX_HOURS, 8'h00);
    chk(q, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs();
    t_count();
    t_periodic();
    t_hour();
    t_reset();
    tally_and_finish();
  end
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end
endmodule
